/* logic/tcc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
    import tcc_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADR_W-1:0] reg_addr,
    input wire logic [DAT_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DAT_W-1:0] reg_rdata,
    input wire logic event_count_input,
    input wire logic [2:0] external_clear_input,
    input wire logic [NUM_TRIG-1:0] capture_trigger_pin,
    output logic [2:0] timer_output_pin,
    output tcc_irq_t irq
);
    // prescaler must reach phi/256
    if (DIV_W < 8) begin : g_bad_div
        $error("DIV_W must be at least 8");
    end

    // divide code to shift, code 0 divides by 2; every code ticks
    function automatic logic [3:0] gen_shift(input logic [2:0] c);
        case (c)
            3'h0: gen_shift = 4'h1;
            3'h1: gen_shift = 4'h2;
            3'h2: gen_shift = 4'h3;
            3'h3, 3'h4: gen_shift = 4'h4;
            3'h5, 3'h6: gen_shift = 4'h5;
            default: gen_shift = 4'h6;
        endcase
    endfunction : gen_shift

    // reserved codes yield no tick at all
    function automatic logic [3:0] int_shift(input logic [2:0] c);
        case (c)
            3'h0: int_shift = 4'h5;
            3'h1, 3'h4: int_shift = 4'h6;
            3'h2, 3'h5: int_shift = 4'h7;
            3'h6: int_shift = 4'h8;
            default: int_shift = 4'h0;
        endcase
    endfunction : int_shift

    // one-cycle tick every 2^k clocks
    function automatic logic div_tick(input logic [DIV_W-1:0] d,
                                      input logic [3:0] k);
        logic [DIV_W-1:0] mask;
        mask = DIV_W'((1 << k) - 1);
        div_tick = (k != 4'h0) && ((d & mask) == mask);
    endfunction : div_tick

    // edge select; the reserved code counts nothing
    function automatic logic edge_hit(input logic [1:0] m, input logic r,
                                      input logic f);
        case (m)
            EDGE_RISE: edge_hit = r;
            EDGE_FALL: edge_hit = f;
            EDGE_BOTH: edge_hit = r | f;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    // free-running prescaler shared by every unit
    logic [DIV_W-1:0] div_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) div_r <= '0;
        else div_r <= div_r + 1'b1;
    end

    // pin synchronisers; stages two and three feed the edge logic
    logic [NUM_SYNC-1:0] sync1_r, sync2_r, sync3_r;
    wire [NUM_SYNC-1:0] pin_raw = {event_count_input, external_clear_input,
                                   capture_trigger_pin};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end
    wire [NUM_SYNC-1:0] pin_rise = sync2_r & ~sync3_r;
    wire [NUM_SYNC-1:0] pin_fall = ~sync2_r & sync3_r;

    // register bus decode
    wire gen_sel = ~reg_addr[5];
    wire [1:0] gen_idx = reg_addr[4:3];
    wire [2:0] gen_reg = reg_addr[2:0];
    wire int_sel = reg_addr[5:3] == 3'h4;
    wire int_idx = reg_addr[2];
    wire [1:0] int_reg = reg_addr[1:0];

    // capture edge mode, two bits per trigger pin
    logic [17:0] emode_r;
    // shared overflow status
    logic [7:0] ovf_r;

    // general unit state
    tcc_gctl_t gctl_r [NUM_GEN];
    tcc_gmode_t gmode_r [NUM_GEN];
    logic [CNT_W-1:0] gcnt_r [NUM_GEN];
    logic [CNT_W-1:0] cc_r [NUM_GEN][4];
    logic [NUM_GEN-1:0] grun_r; // counting now
    logic [NUM_GEN-1:0] gup_r; // counted up last cycle
    logic [NUM_GEN-1:0] govf; // wrap this cycle
    logic [NUM_GEN-1:0] gclr; // clear edge this cycle
    logic [NUM_GEN-1:0] gtick;
    logic [3:0] gmatch [NUM_GEN];
    logic [3:0] gcap [NUM_GEN];
    logic [1:0] octl_r [3]; // {enable, level}
    logic [2:0] out_r; // set/reset flop, active when 1

    // interval unit state
    tcc_ictl_t ictl_r [NUM_INT];
    logic [CNT_W-1:0] icmp_r [NUM_INT];
    logic [CNT_W-1:0] icnt_r [NUM_INT];
    logic [NUM_INT-1:0] iup_r, iclrp_r, itick, imatch, iovf;

    // trigger pin per capture register; unit 2 and registers 1..3 of unit 3 have none
    wire [NUM_TRIG-1:0] trig_hit;
    genvar t;
    for (t = 0; t < NUM_TRIG; t++) begin : g_trig
        assign trig_hit[t] = edge_hit(emode_r[2*t +: 2], pin_rise[t],
                                      pin_fall[t]);
    end

    genvar g, i;
    for (g = 0; g < NUM_GEN; g++) begin : g_gen
        wire wr_u = reg_wr && gen_sel && (gen_idx == 2'(g));
        wire ctl_wr = wr_u && gen_reg == OFF_GCTL;
        wire ce_now = gctl_r[g].ce;
        wire ce_set = ctl_wr && reg_wdata[GCTL_CE];
        wire ext_src = (g == 3) && gctl_r[g].eti;
        wire ev_edge = edge_hit(gmode_r[g].tes, pin_rise[12],
                                pin_fall[12]);
        wire int_tick = div_tick(div_r, gen_shift({gctl_r[g].prs,
                                 gctl_r[g].prm}));
        wire top = gcnt_r[g] == CNT_TOP;
        // a restart after an overflow stop needs the clear input if armed
        wire start = ce_set && !gmode_r[g].eclr;
        wire up_now = ce_now && grun_r[g] && gtick[g] && !gclr[g];
        wire [CNT_W-1:0] cnt_nxt = (!ce_now || gclr[g]) ? CNT_ZERO :
                                   up_now ? gcnt_r[g] + 1'b1 : gcnt_r[g];
        wire run_nxt = !ce_now ? start : gclr[g] ? 1'b1 :
                       start ? 1'b1 :
                       (up_now && top && gmode_r[g].ost) ? 1'b0 :
                       grun_r[g];
        assign gtick[g] = ext_src ? ev_edge : int_tick;
        // clear input exists on units 0..2 only
        if (g < 3) begin : g_clr
            wire clr_edge = edge_hit(gmode_r[g].ces, pin_rise[9+g],
                                     pin_fall[9+g]);
            assign gclr[g] = ce_now && gmode_r[g].eclr && clr_edge;
        end else begin : g_noclr
            assign gclr[g] = 1'b0;
        end
        assign govf[g] = up_now && top;

        for (i = 0; i < 4; i++) begin : g_cc
            wire cc_wr = wr_u && gen_reg == (OFF_CC0 + 3'(i));
            wire has_trig = (g < 2) || (g == 3 && i == 0);
            localparam int TI = (g < 2) ? (g * 4 + i) : NUM_TRIG - 1;
            assign gcap[g][i] = has_trig && !gmode_r[g].cms[i] && ce_now
                                && trig_hit[TI];
            assign gmatch[g][i] = gup_r[g] && gmode_r[g].cms[i]
                                  && gcnt_r[g] == cc_r[g][i]
                                  && !cc_wr && !gclr[g];
            // capture wins over a bus write in the same cycle
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) cc_r[g][i] <= CNT_ZERO;
                else if (gcap[g][i]) cc_r[g][i] <= gcnt_r[g];
                else if (cc_wr) cc_r[g][i] <= reg_wdata;
            end
        end

        // control, mode and counter for one general unit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                gctl_r[g] <= '0;
                gmode_r[g] <= '0;
                gcnt_r[g] <= CNT_ZERO;
                grun_r[g] <= 1'b0;
                gup_r[g] <= 1'b0;
            end else begin
                if (ctl_wr) gctl_r[g] <= {reg_wdata[GCTL_CE],
                    (g == 3) & reg_wdata[GCTL_ETI],
                    reg_wdata[GCTL_PRS +: 2], reg_wdata[GCTL_PRM]};
                if (wr_u && gen_reg == OFF_GMODE)
                    gmode_r[g] <= reg_wdata[9:0];
                gcnt_r[g] <= cnt_nxt;
                grun_r[g] <= run_nxt;
                gup_r[g] <= up_now;
            end
        end

        // set/reset output for units 0..2
        if (g < 3) begin : g_out
            wire ento = octl_r[g][1];
            wire alv = octl_r[g][0];
            // reset has priority over set
            wire o_nxt = !ento ? 1'b0 : gmatch[g][1] ? 1'b0 :
                         gmatch[g][0] ? 1'b1 : out_r[g];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    octl_r[g] <= 2'h0;
                    out_r[g] <= 1'b0;
                    timer_output_pin[g] <= PIN_RST;
                end else begin
                    if (wr_u && gen_reg == OFF_OCTL)
                        octl_r[g] <= {reg_wdata[OCTL_ENTO],
                                      reg_wdata[OCTL_ALV]};
                    out_r[g] <= o_nxt;
                    timer_output_pin[g] <= o_nxt ? alv : !alv;
                end
            end
        end
    end

    genvar k;
    for (k = 0; k < NUM_INT; k++) begin : g_int
        wire wr_u = reg_wr && int_sel && (int_idx == 1'(k));
        wire cmp_wr = wr_u && int_reg == OFF_ICMP;
        wire ce_now = ictl_r[k].ce;
        assign itick[k] = ce_now && div_tick(div_r, int_shift({ictl_r[k].prs,
                          ictl_r[k].prm}));
        // a pending clear uses up the tick instead of counting
        wire up_now = itick[k] && !iclrp_r[k];
        assign iovf[k] = up_now && icnt_r[k] == CNT_TOP;
        assign imatch[k] = iup_r[k] && icnt_r[k] == icmp_r[k]
                           && !cmp_wr;
        wire [CNT_W-1:0] cnt_nxt = !ce_now ? CNT_ZERO :
                                   !itick[k] ? icnt_r[k] :
                                   iclrp_r[k] ? CNT_ZERO :
                                   icnt_r[k] + 1'b1;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                ictl_r[k] <= '0;
                icmp_r[k] <= CNT_ZERO;
                icnt_r[k] <= CNT_ZERO;
                iup_r[k] <= 1'b0;
                iclrp_r[k] <= 1'b0;
            end else begin
                if (wr_u && int_reg == OFF_ICTL)
                    ictl_r[k] <= {reg_wdata[ICTL_CE], reg_wdata[ICTL_PRS],
                                  reg_wdata[ICTL_PRM +: 2]};
                if (cmp_wr) icmp_r[k] <= reg_wdata;
                icnt_r[k] <= cnt_nxt;
                iup_r[k] <= up_now;
                iclrp_r[k] <= !ce_now ? 1'b0 : imatch[k] ? 1'b1 :
                              itick[k] ? 1'b0 : iclrp_r[k];
            end
        end
    end

    // gathered event vectors
    wire [15:0] cc_evt = {gmatch[3] | gcap[3], gmatch[2] | gcap[2],
                          gmatch[1] | gcap[1], gmatch[0] | gcap[0]};
    wire [7:0] ovf_set = {iovf, 2'b00, govf};

    // status flags: hardware set wins over a software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_r <= 8'h00;
            emode_r <= '0;
            irq <= '0;
        end else begin
            ovf_r <= ((reg_wr && reg_addr == ADR_OVF) ?
                      reg_wdata[7:0] & OVF_MASK : ovf_r) | ovf_set;
            if (reg_wr && reg_addr == ADR_EDGE_A)
                emode_r[15:0] <= reg_wdata;
            if (reg_wr && reg_addr == ADR_EDGE_B)
                emode_r[17:16] <= reg_wdata[1:0];
            irq <= {cc_evt, govf, imatch};
        end
    end

    // read mux; unmapped addresses read zero
    logic [DAT_W-1:0] rd_val;
    always_comb begin
        rd_val = '0;
        if (gen_sel) begin
            case (gen_reg)
                OFF_GCTL: rd_val = 16'(gctl_r[gen_idx].ce) << GCTL_CE
                    | 16'(gctl_r[gen_idx].eti) << GCTL_ETI
                    | 16'(gctl_r[gen_idx].prs) << GCTL_PRS
                    | 16'(gctl_r[gen_idx].prm) << GCTL_PRM;
                OFF_GMODE: rd_val = 16'(gmode_r[gen_idx]);
                OFF_GCNT: rd_val = gcnt_r[gen_idx];
                OFF_OCTL: rd_val = (gen_idx == 2'h3) ? 16'h0000 :
                    16'(octl_r[gen_idx]) << OCTL_ALV;
                default: rd_val = cc_r[gen_idx][gen_reg[1:0]];
            endcase
        end else if (int_sel) begin
            case (int_reg)
                OFF_ICTL: rd_val = 16'(ictl_r[int_idx].ce) << ICTL_CE
                    | 16'(ictl_r[int_idx].prs) << ICTL_PRS
                    | 16'(ictl_r[int_idx].prm) << ICTL_PRM;
                OFF_ICMP: rd_val = icmp_r[int_idx];
                OFF_ICNT: rd_val = icnt_r[int_idx];
                default: rd_val = '0;
            endcase
        end else if (reg_addr == ADR_OVF) begin
            rd_val = {8'h00, ovf_r};
        end else if (reg_addr == ADR_EDGE_A) begin
            rd_val = emode_r[15:0];
        end else if (reg_addr == ADR_EDGE_B) begin
            rd_val = {14'h0000, emode_r[17:16]};
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) reg_rdata <= '0;
        else reg_rdata <= reg_rd ? rd_val : '0;
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_ost_wrap;
        govf[1] && gmode_r[1].ost && !gclr[1] && !reg_wr;
    endsequence
    sequence s_stays_idle;
        !grun_r[1] ##1 !grun_r[1];
    endsequence

    a_idle_zero: assert property (
        !gctl_r[0].ce |=> gcnt_r[0] == CNT_ZERO)
        else $error("disabled counter not zero");
    a_wrap_flag: assert property (
        govf[2] |=> ovf_r[2] && irq.general_overflow_irq[2]
                    && gcnt_r[2] == CNT_ZERO)
        else $error("wrap did not flag");
    a_ost_halt: assert property (
        s_ost_wrap ##1 (!gclr[1] && !(reg_wr && reg_addr == 6'h08))
        |-> s_stays_idle)
        else $error("counter ran after overflow stop");
    a_capture_value: assert property (
        gcap[0][0] |=> cc_r[0][0] == $past(gcnt_r[0])
                       && irq.capcmp_irq[0])
        else $error("capture value lost");
    a_match_timing: assert property (
        $rose(irq.capcmp_irq[8]) && gmode_r[2].cms[0]
        |-> $past(gup_r[2]))
        else $error("match without count-up");
    a_out_set: assert property (
        octl_r[2][1] && gmatch[2][0] && !gmatch[2][1]
        |=> timer_output_pin[2] == $past(octl_r[2][0]))
        else $error("output not set on match");
    a_out_idle: assert property (
        !octl_r[1][1] |=> timer_output_pin[1] == !$past(octl_r[1][0]))
        else $error("disabled output not inactive");
    a_int_clear: assert property (
        iclrp_r[0] && itick[0]
        |=> icnt_r[0] == CNT_ZERO ##1 !irq.interval_match_irq[0])
        else $error("interval clear wrong");
    a_cap_none_u2: assert property (
        gcap[2] == 4'h0)
        else $error("unit 2 captured");
endmodule : tcc_timer
`default_nettype wire

/* include/tcc_pkg.sv */
package tcc_pkg;
    // unit counts and widths
    localparam int NUM_GEN = 4;
    localparam int NUM_INT = 2;
    localparam int NUM_TRIG = 9;
    localparam int NUM_SYNC = 13;
    localparam int CNT_W = 16;
    localparam int DAT_W = 16;
    localparam int ADR_W = 6;
    localparam logic [CNT_W-1:0] CNT_TOP = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

    // clock figures
    localparam int CLK_PERIOD_NS = 10;

    // address map: general unit g at g*8, interval unit k at 0x20 + k*4
    localparam logic [2:0] OFF_GCTL = 3'h0;
    localparam logic [2:0] OFF_GMODE = 3'h1;
    localparam logic [2:0] OFF_GCNT = 3'h2;
    localparam logic [2:0] OFF_OCTL = 3'h3;
    localparam logic [2:0] OFF_CC0 = 3'h4;
    localparam logic [1:0] OFF_ICTL = 2'h0;
    localparam logic [1:0] OFF_ICMP = 2'h1;
    localparam logic [1:0] OFF_ICNT = 2'h2;
    localparam logic [ADR_W-1:0] ADR_OVF = 6'h30;
    localparam logic [ADR_W-1:0] ADR_EDGE_A = 6'h31;
    localparam logic [ADR_W-1:0] ADR_EDGE_B = 6'h32;

    // field positions
    localparam int GCTL_CE = 7;
    localparam int GCTL_ETI = 4;
    localparam int GCTL_PRS = 2;
    localparam int GCTL_PRM = 1;
    localparam int GMODE_CMS = 0;
    localparam int GMODE_CES = 4;
    localparam int GMODE_TES = 6;
    localparam int GMODE_ECLR = 8;
    localparam int GMODE_OST = 9;
    localparam int OCTL_ENTO = 5;
    localparam int OCTL_ALV = 4;
    localparam int ICTL_CE = 7;
    localparam int ICTL_PRS = 2;
    localparam int ICTL_PRM = 0;
    localparam int OVF_INT0 = 6;
    localparam logic [7:0] OVF_MASK = 8'hcf;

    // edge select codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // reset values
    localparam logic PIN_RST = 1'b1;

    typedef struct packed {
        logic ce;
        logic eti;
        logic [1:0] prs;
        logic prm;
    } tcc_gctl_t;

    typedef struct packed {
        logic ost;
        logic eclr;
        logic [1:0] tes;
        logic [1:0] ces;
        logic [3:0] cms;
    } tcc_gmode_t;

    typedef struct packed {
        logic ce;
        logic prs;
        logic [1:0] prm;
    } tcc_ictl_t;

    typedef struct packed {
        logic [15:0] capcmp_irq;
        logic [3:0] general_overflow_irq;
        logic [1:0] interval_match_irq;
    } tcc_irq_t;
endpackage : tcc_pkg

/* verif/tcc_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side of the block: trigger, clear and event pins
module tcc_pin_model import tcc_pkg::*; (
    input wire logic clk,
    output var logic event_count_input,
    output var logic [2:0] external_clear_input,
    output var logic [NUM_TRIG-1:0] capture_trigger_pin
);
    // push-pull sources, so idle low is a real level, not a released line
    initial begin
        event_count_input = 1'b0;
        external_clear_input = 3'h0;
        capture_trigger_pin = '0;
    end

    // one high pulse; 4 clocks per level so the 3-flop sync never misses it
    // kind 0 capture trigger, 1 clear/start, else event input
    task automatic pulse(input int kind, input int idx);
        for (int lvl = 1; lvl >= 0; lvl--) begin
            @(posedge clk);
            case (kind)
                0: capture_trigger_pin[idx] <= lvl[0];
                1: external_clear_input[idx] <= lvl[0];
                default: event_count_input <= lvl[0];
            endcase
            repeat (3) @(posedge clk);
        end
    endtask : pulse
endmodule : tcc_pin_model
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// register-level bench; overflow paths need 65536 ticks and are left out
module testbench import tcc_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADR_W-1:0] reg_addr = '0;
    logic [DAT_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DAT_W-1:0] reg_rdata;
    logic event_count_input;
    logic [2:0] external_clear_input;
    logic [NUM_TRIG-1:0] capture_trigger_pin;
    logic [2:0] timer_output_pin;
    tcc_irq_t irq;
    wire logic [21:0] irq_v = irq; // flat view of all requests
    int error_cnt = 0;
    int n_compared = 0;
    int hits [22]; // request pulses seen per bit
    logic hits_clr = 1'b0;
    logic [DAT_W-1:0] d;
    logic [DAT_W-1:0] c1;
    int cyc;
    int divs [8] = '{2, 4, 8, 16, 16, 32, 32, 64}; // general prescale
    int idivs [8] = '{32, 64, 128, 0, 64, 128, 256, 0}; // 0 = reserved
    int ev_exp [4] = '{3, 3, 0, 6}; // three pulses, by edge code
    int cap_exp [4] = '{1, 1, 0, 2}; // one pulse, by edge code

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    tcc_timer #(.DIV_W(8)) u_tcc_timer (
        .clk(clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .event_count_input(event_count_input),
        .external_clear_input(external_clear_input),
        .capture_trigger_pin(capture_trigger_pin),
        .timer_output_pin(timer_output_pin),
        .irq(irq)
    );

    tcc_pin_model u_tcc_pin_model (
        .clk(clk),
        .event_count_input(event_count_input),
        .external_clear_input(external_clear_input),
        .capture_trigger_pin(capture_trigger_pin)
    );

    // count one-cycle request pulses, cleared on request
    always @(posedge clk) begin
        for (int i = 0; i < 22; i++) begin
            if (hits_clr) hits[i] <= 0;
            else if (irq_v[i] === 1'b1) hits[i] <= hits[i] + 1;
        end
    end

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk

    // gap of one cycle between strobes keeps each signal single-driven
    task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [ADR_W-1:0] a, output logic [DAT_W-1:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd

    // cycles until request bit b is next high, bounded
    task automatic wait_bit(input int b, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (irq_v[b] !== 1'b1 && n < 3000);
        chk(n < 3000, "request timeout");
    endtask : wait_bit

    task automatic clr_hits();
        @(posedge clk);
        hits_clr <= 1'b1;
        @(posedge clk);
        hits_clr <= 1'b0;
    endtask : clr_hits

    task automatic note(input string s);
        $display("test done: %s", s);
    endtask : note

    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // watchdog, well beyond the roughly 9k cycles the tests need
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        int ci;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(6'h02, d);
        chk(d === 16'h0000, "counter after reset");
        rd(6'h3f, d);
        chk(d === 16'h0000, "unmapped read");
        chk(timer_output_pin === 3'b111, "pins after reset");
        note("reset");
        // every general prescale code on unit 0
        for (int c = 0; c < 8; c++) begin
            wr(6'h00, 16'h0080 | (16'(c) << 1));
            repeat (640) @(posedge clk);
            rd(6'h02, d);
            chk(int'(d) >= 640 / divs[c] - 2 && int'(d) <= 640 / divs[c] + 2,
                "general rate");
            wr(6'h00, 16'h0000);
            rd(6'h02, d);
            chk(d === 16'h0000, "stopped at zero");
        end
        note("prescale");
        wr(6'h00, 16'h0080);
        repeat (200) @(posedge clk);
        rd(6'h02, c1);
        wr(6'h00, 16'h0080);
        rd(6'h02, d);
        chk(d > c1 && d < c1 + 16'h0008, "enable rewrite");
        note("enable rewrite");
        // every trigger pin lands in its own register and request
        wr(6'h08, 16'h0080);
        wr(6'h18, 16'h0080);
        for (int p = 0; p < 9; p++) begin
            ci = (p == 8) ? 12 : p;
            clr_hits();
            u_tcc_pin_model.pulse(0, p);
            rd(6'(ci / 4 * 8 + 4 + ci % 4), d);
            rd(6'(ci / 4 * 8 + 2), c1);
            chk(hits[6 + ci] == 1 && d !== 16'h0000 && d < c1,
                "capture");
        end
        for (int e = 0; e < 4; e++) begin
            wr(ADR_EDGE_A, 16'(e) << 8);
            clr_hits();
            u_tcc_pin_model.pulse(0, 4);
            repeat (6) @(posedge clk);
            chk(hits[10] == cap_exp[e], "capture edge");
        end
        wr(ADR_EDGE_A, 16'h0000);
        note("capture");
        // unit 3 as event counter, each edge code
        for (int e = 0; e < 4; e++) begin
            wr(6'h18, 16'h0000);
            wr(6'h19, 16'(e) << 6);
            wr(6'h18, 16'h0090);
            repeat (3) u_tcc_pin_model.pulse(2, 0);
            repeat (6) @(posedge clk);
            rd(6'h1a, d);
            chk(d === 16'(ev_exp[e]), "event count");
        end
        wr(6'h18, 16'h0000);
        note("event count");
        // unit 1 waits for the clear edge, later edges zero it
        wr(6'h08, 16'h0000);
        wr(6'h09, 16'h0100);
        wr(6'h08, 16'h0080);
        repeat (40) @(posedge clk);
        rd(6'h0a, d);
        chk(d === 16'h0000, "waits for clear edge");
        u_tcc_pin_model.pulse(1, 1);
        repeat (40) @(posedge clk);
        rd(6'h0a, c1);
        chk(c1 > 16'h000a, "started by clear edge");
        u_tcc_pin_model.pulse(1, 1);
        rd(6'h0a, d);
        chk(d < 16'h0008, "zeroed by clear edge");
        note("external clear");
        // unit 2 set/reset output, active high
        wr(6'h13, 16'h0010);
        repeat (3) @(posedge clk);
        #1 chk(timer_output_pin[2] === 1'b0, "inactive level");
        wr(6'h11, 16'h0003);
        wr(6'h14, 16'h0010);
        wr(6'h15, 16'h0030);
        wr(6'h10, 16'h0080);
        wait_bit(14, cyc);
        chk(timer_output_pin[2] === 1'b0, "match while disabled");
        wr(6'h13, 16'h0030);
        wr(6'h14, 16'h0020);
        wait_bit(14, cyc);
        chk(timer_output_pin[2] === 1'b1, "set by match0");
        wait_bit(15, cyc);
        chk(timer_output_pin[2] === 1'b0 && cyc == 32, "match1 resets");
        chk(timer_output_pin[1:0] === 2'b11, "other pins idle");
        rd(6'h11, d);
        chk(d === 16'h0003, "mode readback");
        note("compare output");
        // overflow flags are software writable; bits 5:4 do not exist
        wr(ADR_OVF, 16'h00ff);
        rd(ADR_OVF, d);
        chk(d === {8'h00, OVF_MASK}, "overflow status write");
        wr(ADR_OVF, 16'h0000);
        rd(ADR_OVF, d);
        chk(d === 16'h0000, "overflow status clear");
        wr(ADR_EDGE_B, 16'hffff);
        rd(ADR_EDGE_B, d);
        chk(d === 16'h0003, "unit 3 trigger edge");
        note("status");
        // interval unit 0, compare one gives two ticks per period
        wr(6'h21, 16'h0001);
        for (int c = 0; c < 8; c++) begin
            wr(6'h20, 16'h0000);
            wr(6'h20, 16'h0080 | 16'(c));
            if (idivs[c] == 0) begin
                repeat (300) @(posedge clk);
                rd(6'h22, d);
                chk(d === 16'h0000, "reserved code idle");
            end else begin
                wait_bit(0, cyc);
                wait_bit(0, cyc);
                chk(cyc == 2 * idivs[c], "interval period");
            end
        end
        wr(6'h20, 16'h0000);
        note("interval");
        end_sim();
    end
endmodule : testbench
`default_nettype wire
